// ==== rtl/pfcr_consts.vh ====
`ifndef PFCR_CONSTS_VH
`define PFCR_CONSTS_VH
// Register addresses
`define PFCR_ADDR_DEV_CFG_ONE 8'h03
`define PFCR_ADDR_DEV_CFG_TWO 8'h04
`define PFCR_ADDR_GLOBAL_CFG 8'h05
`define PFCR_ADDR_RATIO_BASE 8'h06
`define PFCR_ADDR_RATIO_LAST 8'h15
`define PFCR_ADDR_FUNC_CFG_ONE 8'h16
`define PFCR_ADDR_FUNC_CFG_TWO 8'h17
`define PFCR_ADDR_FUNC_CFG_THREE 8'h1E
// Field positions
`define PFCR_POS_DEV_CFG_EN_ONE 0
`define PFCR_POS_DEV_CFG_EN_TWO 0
`define PFCR_POS_FRACN_SRC 0
`define PFCR_POS_LOCK_SEL 1
`define PFCR_POS_REF_DIV 3
`define PFCR_POS_RATIO_FMT 3
`define PFCR_POS_OUT_UNLOCK 4
`define PFCR_POS_MIN_BW 4
// Writable bit masks, reserved bits read zero
`define PFCR_MASK_DEV_CFG_ONE 8'h01
`define PFCR_MASK_DEV_CFG_TWO 8'h07
`define PFCR_MASK_GLOBAL_CFG 8'h01
`define PFCR_MASK_FUNC_CFG_ONE 8'h18
`define PFCR_MASK_FUNC_CFG_TWO 8'h18
`define PFCR_MASK_FUNC_CFG_THREE 8'h70
// Reset values
`define PFCR_RST_BYTE 8'h00
// Divider codes
`define PFCR_DIV_BY4 2'h0
`define PFCR_DIV_BY2 2'h1
`define PFCR_DIV_BY1 2'h2
`endif

// ==== rtl/pfcr_ref_divider.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pfcr_consts.vh"
module pfcr_ref_divider (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // Control
  input wire [1:0] i_div_sel,
  // Divided timing enable
  output reg o_tick_ff
);
  reg [1:0] cnt_ff;
  reg [1:0] nxt_cnt;
  reg [1:0] last_cnt;
  reg nxt_tick;

  // Terminal count per divide code, reserved code stops the tick
  always @* begin
    last_cnt = 2'h0;
    nxt_tick = 1'b0;
    case (i_div_sel)
      `PFCR_DIV_BY4: last_cnt = 2'h3;
      `PFCR_DIV_BY2: last_cnt = 2'h1;
      `PFCR_DIV_BY1: last_cnt = 2'h0;
      default: last_cnt = 2'h0;
    endcase
    nxt_cnt = (cnt_ff >= last_cnt) ? 2'h0 : cnt_ff + 2'h1;
    if (i_div_sel != 2'h3) begin
      nxt_tick = (cnt_ff >= last_cnt);
    end
  end

  // Counter and enable pulse
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ff <= 2'h0;
      o_tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      o_tick_ff <= nxt_tick;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/pfcr_regs.v ====
// Function
// - The reference divide field divides the timing reference by 4, 2 or 1 for codes 00, 01, 10; 11 is reserved.
// - With out_on_unlock_en at 0 the clock outputs are held low whenever the loop is unlocked.
// - With out_on_unlock_en at 1 the clock outputs run whenever both device configuration enables are set, even unlocked.
// - In hybrid mode with ratio_format_sel at 0 the ratio is read as 20 integer and 12 fraction bits.
// - In hybrid mode with ratio_format_sel at 1 the ratio is read as 12 integer and 20 fraction bits.
// - In static synthesizer mode the ratio is always read as 12.20, whatever ratio_format_sel holds.
// - The format applies to whichever stored ratio is indexed, chosen by software or automatically.
// - The bandwidth field sets the minimum locked loop bandwidth to 1 Hz shifted left by its code.
// - A new bandwidth setting is only sure to apply if written before lock or while normal operation is off; otherwise changing it needs an unlock.
// - Each stored ratio lies in four byte registers, most significant byte at the lowest address.
// - Normal operation starts only once both device configuration enables are set, in either order.
`timescale 1ns/1ps
`default_nettype none
`include "pfcr_consts.vh"
module pfcr_regs (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // Register port from the control port transport
  input wire i_reg_wr,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata_ff,
  // Loop status and clock sources
  input wire i_pll_locked,
  input wire i_pll_clk,
  input wire i_auto_hybrid,
  input wire i_auto_sel_valid,
  input wire [1:0] i_auto_ratio_sel,
  // Clock output and timing enable
  output reg o_clk_out_ff,
  output reg o_timing_tick_ff,
  // Synthesizer settings
  output reg o_normal_op_ff,
  output reg o_hybrid_mode_ff,
  output reg o_ratio_12_20_ff,
  output reg [31:0] o_ratio_ff,
  output reg [7:0] o_min_bw_hz_ff,
  output reg [2:0] o_min_bw_applied_ff
);
  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [7:0] dev_cfg_one_ff;
  reg [7:0] dev_cfg_two_ff;
  reg [7:0] global_cfg_ff;
  reg [7:0] func_cfg_one_ff;
  reg [7:0] func_cfg_two_ff;
  reg [7:0] func_cfg_three_ff;
  reg [7:0] ratio_mem_ff [0:15];
  reg [7:0] nxt_rdata;
  reg lock_s1_ff;
  reg lock_s2_ff;
  reg clk_s1_ff;
  reg clk_s2_ff;
  reg auto_h_s1_ff;
  reg auto_h_s2_ff;
  reg auto_v_s1_ff;
  reg auto_v_s2_ff;
  reg [1:0] auto_r_s1_ff;
  reg [1:0] auto_r_s2_ff;
  wire div_tick;
  wire [1:0] ref_divide_sel;
  wire out_on_unlock_en;
  wire ratio_format_sel;
  wire [2:0] min_loop_bw_sel;
  wire device_cfg_enable;
  wire manual_hybrid;
  wire hybrid_now;
  wire [1:0] ratio_index;
  wire [3:0] ratio_base;
  wire [31:0] ratio_word;
  wire ratio_hit;
  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction
  assign ref_divide_sel = func_cfg_one_ff[`PFCR_POS_REF_DIV+1:`PFCR_POS_REF_DIV];
  assign out_on_unlock_en = func_cfg_two_ff[`PFCR_POS_OUT_UNLOCK];
  assign ratio_format_sel = func_cfg_two_ff[`PFCR_POS_RATIO_FMT];
  assign min_loop_bw_sel = func_cfg_three_ff[`PFCR_POS_MIN_BW+2:`PFCR_POS_MIN_BW];
  assign manual_hybrid = dev_cfg_two_ff[`PFCR_POS_FRACN_SRC];
  // Both enables in either order start normal operation
  assign device_cfg_enable = dev_cfg_one_ff[`PFCR_POS_DEV_CFG_EN_ONE] &
                             global_cfg_ff[`PFCR_POS_DEV_CFG_EN_TWO];
  // Automatic source selection overrides the manual choice when valid
  assign hybrid_now = auto_v_s2_ff ? auto_h_s2_ff : manual_hybrid;
  assign ratio_index = auto_v_s2_ff ? auto_r_s2_ff :
                       dev_cfg_two_ff[`PFCR_POS_LOCK_SEL+1:`PFCR_POS_LOCK_SEL];
  assign ratio_base = {ratio_index, 2'h0};
  // Most significant byte at the lowest address of each group
  assign ratio_word = {ratio_mem_ff[ratio_base], ratio_mem_ff[ratio_base + 4'h1],
                       ratio_mem_ff[ratio_base + 4'h2], ratio_mem_ff[ratio_base + 4'h3]};
  assign ratio_hit = (i_reg_addr >= `PFCR_ADDR_RATIO_BASE) && (i_reg_addr <= `PFCR_ADDR_RATIO_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for inputs from outside the clock domain
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      auto_h_s1_ff <= 1'b0;
      auto_h_s2_ff <= 1'b0;
      auto_v_s1_ff <= 1'b0;
      auto_v_s2_ff <= 1'b0;
      auto_r_s1_ff <= 2'h0;
      auto_r_s2_ff <= 2'h0;
    end else begin
      lock_s1_ff <= i_pll_locked;
      lock_s2_ff <= lock_s1_ff;
      clk_s1_ff <= i_pll_clk;
      clk_s2_ff <= clk_s1_ff;
      auto_h_s1_ff <= i_auto_hybrid;
      auto_h_s2_ff <= auto_h_s1_ff;
      auto_v_s1_ff <= i_auto_sel_valid;
      auto_v_s2_ff <= auto_v_s1_ff;
      auto_r_s1_ff <= i_auto_ratio_sel;
      auto_r_s2_ff <= auto_r_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, reserved bits masked to zero
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dev_cfg_one_ff <= `PFCR_RST_BYTE;
      dev_cfg_two_ff <= `PFCR_RST_BYTE;
      global_cfg_ff <= `PFCR_RST_BYTE;
      func_cfg_one_ff <= `PFCR_RST_BYTE;
      func_cfg_two_ff <= `PFCR_RST_BYTE;
      func_cfg_three_ff <= `PFCR_RST_BYTE;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `PFCR_ADDR_DEV_CFG_ONE: dev_cfg_one_ff <= i_reg_wdata & `PFCR_MASK_DEV_CFG_ONE;
        `PFCR_ADDR_DEV_CFG_TWO: dev_cfg_two_ff <= i_reg_wdata & `PFCR_MASK_DEV_CFG_TWO;
        `PFCR_ADDR_GLOBAL_CFG: global_cfg_ff <= i_reg_wdata & `PFCR_MASK_GLOBAL_CFG;
        `PFCR_ADDR_FUNC_CFG_ONE: func_cfg_one_ff <= i_reg_wdata & `PFCR_MASK_FUNC_CFG_ONE;
        `PFCR_ADDR_FUNC_CFG_TWO: func_cfg_two_ff <= i_reg_wdata & `PFCR_MASK_FUNC_CFG_TWO;
        `PFCR_ADDR_FUNC_CFG_THREE: func_cfg_three_ff <= i_reg_wdata & `PFCR_MASK_FUNC_CFG_THREE;
        default: ;
      endcase
    end
  end

  // Ratio byte storage, sixteen bytes in four groups
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (i = 0; i < 16; i = i + 1) begin
        ratio_mem_ff[i] <= `PFCR_RST_BYTE;
      end
    end else if (i_reg_wr && ratio_hit) begin
      ratio_mem_ff[i_reg_addr[3:0] - 4'h6] <= i_reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, unmapped addresses read zero
  always @* begin
    nxt_rdata = 8'h00;
    if (ratio_hit) begin
      nxt_rdata = ratio_mem_ff[i_reg_addr[3:0] - 4'h6];
    end else begin
      case (i_reg_addr)
        `PFCR_ADDR_DEV_CFG_ONE: nxt_rdata = dev_cfg_one_ff;
        `PFCR_ADDR_DEV_CFG_TWO: nxt_rdata = dev_cfg_two_ff;
        `PFCR_ADDR_GLOBAL_CFG: nxt_rdata = global_cfg_ff;
        `PFCR_ADDR_FUNC_CFG_ONE: nxt_rdata = func_cfg_one_ff;
        `PFCR_ADDR_FUNC_CFG_TWO: nxt_rdata = func_cfg_two_ff;
        `PFCR_ADDR_FUNC_CFG_THREE: nxt_rdata = func_cfg_three_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata_ff <= 8'h00;
    end else begin
      o_reg_rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing reference divider
  pfcr_ref_divider u_ref_divider (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_div_sel(ref_divide_sel),
    .o_tick_ff(div_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Derived settings and gated clock output
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_clk_out_ff <= 1'b0;
      o_timing_tick_ff <= 1'b0;
      o_normal_op_ff <= 1'b0;
      o_hybrid_mode_ff <= 1'b0;
      o_ratio_12_20_ff <= 1'b1;
      o_ratio_ff <= 32'h00000000;
      o_min_bw_hz_ff <= 8'h01;
      o_min_bw_applied_ff <= 3'h0;
    end else begin
      o_timing_tick_ff <= div_tick;
      o_normal_op_ff <= device_cfg_enable;
      // Outputs low while unlocked unless the enable keeps them running
      if (!device_cfg_enable) begin
        o_clk_out_ff <= 1'b0;
      end else if (lock_s2_ff || out_on_unlock_en) begin
        o_clk_out_ff <= clk_s2_ff;
      end else begin
        o_clk_out_ff <= 1'b0;
      end
      o_hybrid_mode_ff <= hybrid_now;
      // Static mode forces 12.20, hybrid follows the format bit
      o_ratio_12_20_ff <= hybrid_now ? ratio_format_sel : 1'b1;
      o_ratio_ff <= ratio_word;
      o_min_bw_hz_ff <= 8'h01 << min_loop_bw_sel;
      // Bandwidth only takes effect while not locked or while normal operation is off
      if (!lock_s2_ff || !device_cfg_enable) begin
        o_min_bw_applied_ff <= min_loop_bw_sel;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/pfcr_regs_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pfcr_consts.vh"
module pfcr_regs_chk (
  // Clock, reset and register port
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_reg_wr,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire [7:0] o_reg_rdata_ff,
  // Loop status and settings
  input wire i_pll_locked,
  input wire o_clk_out_ff,
  input wire o_timing_tick_ff,
  input wire o_normal_op_ff,
  input wire o_hybrid_mode_ff,
  input wire o_ratio_12_20_ff,
  input wire [7:0] o_min_bw_hz_ff
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  reg en1_ff, en2_ff, unl_ff;
  reg [1:0] div_ff, clean_ff;
  reg [2:0] gap_ff;
  // Addresses that hold a register
  wire mapped = (i_reg_addr >= `PFCR_ADDR_DEV_CFG_ONE && i_reg_addr <= `PFCR_ADDR_FUNC_CFG_TWO) ||
    (i_reg_addr == `PFCR_ADDR_FUNC_CFG_THREE);
  // Shadow written control bits; count cycles between ticks, trusted after three clean ticks
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en1_ff <= 1'b0;
      en2_ff <= 1'b0;
      unl_ff <= 1'b0;
      div_ff <= 2'h0;
      clean_ff <= 2'h0;
      gap_ff <= 3'h0;
    end else begin
      if (i_reg_wr && i_reg_addr == `PFCR_ADDR_DEV_CFG_ONE) en1_ff <= i_reg_wdata[0];
      if (i_reg_wr && i_reg_addr == `PFCR_ADDR_GLOBAL_CFG) en2_ff <= i_reg_wdata[0];
      if (i_reg_wr && i_reg_addr == `PFCR_ADDR_FUNC_CFG_TWO) unl_ff <= i_reg_wdata[4];
      if (i_reg_wr && i_reg_addr == `PFCR_ADDR_FUNC_CFG_ONE) begin
        div_ff <= i_reg_wdata[4:3];
        clean_ff <= 2'h0;
      end else if (o_timing_tick_ff && clean_ff != 2'h3) begin
        clean_ff <= clean_ff + 2'h1;
      end
      gap_ff <= o_timing_tick_ff ? 3'h0 : gap_ff + {2'h0, gap_ff != 3'h7};
    end
  end
  sequence s_unlocked_gated;
    (!unl_ff && !i_pll_locked) [*4];
  endsequence
  sequence s_both_en;
    (en1_ff && en2_ff) [*2];
  endsequence
  a_rd_unmapped: assert property (!mapped |=> o_reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  a_rsv_two_zero: assert property (i_reg_addr == `PFCR_ADDR_FUNC_CFG_TWO |=> (o_reg_rdata_ff & 8'hE7) == 8'h00)
    else $error("reserved bits set in config two");
  a_rsv_three_zero: assert property (i_reg_addr == `PFCR_ADDR_FUNC_CFG_THREE |=> (o_reg_rdata_ff & 8'h8F) == 8'h00)
    else $error("reserved bits set in config three");
  a_bw_onehot: assert property ($onehot(o_min_bw_hz_ff))
    else $error("bandwidth not a power of two");
  a_static_fmt: assert property (!o_hybrid_mode_ff |-> o_ratio_12_20_ff)
    else $error("static mode not read as 12.20");
  a_clk_held_low: assert property (s_unlocked_gated |=> !o_clk_out_ff)
    else $error("clock output runs while unlocked");
  a_tick_reserved: assert property ((div_ff == 2'h3) [*4] |-> !o_timing_tick_ff)
    else $error("tick on reserved divide code");
  a_tick_spacing: assert property (o_timing_tick_ff && clean_ff == 2'h3 |-> gap_ff == (3'h3 >> div_ff))
    else $error("tick spacing wrong for divide code");
  a_normal_on: assert property (s_both_en |-> o_normal_op_ff)
    else $error("normal operation missing with both enables");
endmodule
bind pfcr_regs pfcr_regs_chk u_chk (.i_ref_clk, .i_resetn, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata_ff, .i_pll_locked, .o_clk_out_ff, .o_timing_tick_ff, .o_normal_op_ff, .o_hybrid_mode_ff,
  .o_ratio_12_20_ff, .o_min_bw_hz_ff);
`default_nettype wire

// ==== verif/pfcr_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pfcr_consts.vh"
module pfcr_regs_tb;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, lock = 1'b0, pclk = 1'b0, ahyb = 1'b0, avld = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  logic [1:0] asel = 2'h0, n;
  logic [7:0] mdl [256];
  logic [31:0] d;
  logic [63:0] r;
  int fails = 0, total_checks = 0, k;
  wire [7:0] o_reg_rdata_ff, o_min_bw_hz_ff;
  wire [31:0] o_ratio_ff;
  wire [2:0] o_min_bw_applied_ff;
  wire o_clk_out_ff, o_timing_tick_ff, o_normal_op_ff, o_hybrid_mode_ff, o_ratio_12_20_ff;
  pfcr_regs dut (.i_ref_clk(clk), .i_resetn(rstn), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd),
    .o_reg_rdata_ff, .i_pll_locked(lock), .i_pll_clk(pclk), .i_auto_hybrid(ahyb), .i_auto_sel_valid(avld),
    .i_auto_ratio_sel(asel), .o_clk_out_ff, .o_timing_tick_ff, .o_normal_op_ff, .o_hybrid_mode_ff,
    .o_ratio_12_20_ff, .o_ratio_ff, .o_min_bw_hz_ff, .o_min_bw_applied_ff);
  // Reference clock, and a loop clock that toggles every cycle
  always #50 clk = ~clk;
  always @(posedge clk) pclk <= #1 ~pclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Wait edges, then step just past the last one
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Writable bits of each address in the model
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      `PFCR_ADDR_DEV_CFG_ONE: msk = 8'h01;
      `PFCR_ADDR_DEV_CFG_TWO: msk = 8'h07;
      `PFCR_ADDR_GLOBAL_CFG: msk = 8'h01;
      `PFCR_ADDR_FUNC_CFG_ONE: msk = 8'h18;
      `PFCR_ADDR_FUNC_CFG_TWO: msk = 8'h18;
      `PFCR_ADDR_FUNC_CFG_THREE: msk = 8'h70;
      default: msk = (a >= 8'h06 && a <= 8'h15) ? 8'hFF : 8'h00;
    endcase
  endfunction
  task automatic wrt(input logic [7:0] a, input logic [7:0] v);
    wt(1);
    wr = 1'b1;
    addr = a;
    wd = v;
    wt(1);
    wr = 1'b0;
    mdl[a] = v & msk(a);
  endtask
  task automatic rd(input logic [7:0] a);
    addr = a;
    wt(1);
    check(o_reg_rdata_ff, mdl[a]);
  endtask
  // Count high samples of the clock output or of the tick
  task automatic count(input bit sel, input int cyc);
    k = 0;
    repeat (cyc) begin
      wt(1);
      k += sel ? (o_clk_out_ff === 1'b1) : (o_timing_tick_ff === 1'b1);
    end
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Watchdog at about seventeen times the expected run
  initial begin
    #700000;
    fails++;
    summarize();
  end
  initial begin
    void'($urandom(32'h80f3));
    foreach (mdl[i]) mdl[i] = 8'h00;
    wt(10);
    rstn = 1'b1;
    check({o_normal_op_ff, o_hybrid_mode_ff, o_ratio_12_20_ff, o_min_bw_hz_ff}, 11'h101);
    for (int a = 0; a < 32; a++) begin
      d = $urandom;
      wrt(a[7:0], d[7:0]);
      rd(a[7:0]);
    end
    rd(8'hFF);
    // Bandwidth programmed before the enables, so it is in place at first lock
    wrt(`PFCR_ADDR_FUNC_CFG_THREE, 8'h20);
    wrt(`PFCR_ADDR_DEV_CFG_ONE, 8'h00);
    wrt(`PFCR_ADDR_GLOBAL_CFG, 8'h01);
    wt(2);
    check(o_normal_op_ff, 1'b0);
    wrt(`PFCR_ADDR_DEV_CFG_ONE, 8'h01);
    wt(2);
    check(o_normal_op_ff, 1'b1);
    check(o_min_bw_applied_ff, 3'h2);
    // Format and index: manual, then overridden by automatic selection
    for (int m = 0; m < 8; m++) begin
      n = $urandom_range(3);
      wrt(`PFCR_ADDR_FUNC_CFG_TWO, {4'h0, m[1], 3'h0});
      avld = m[2];
      ahyb = m[0];
      asel = n;
      wrt(`PFCR_ADDR_DEV_CFG_TWO, {5'h0, m[2] ? ~n : n, m[0] ^ m[2]});
      wt(4);
      check(o_hybrid_mode_ff, m[0]);
      check(o_ratio_12_20_ff, m[0] ? m[1] : 1'b1);
      if (m[0]) check(o_ratio_ff, {mdl[6 + 4 * n], mdl[7 + 4 * n], mdl[8 + 4 * n], mdl[9 + 4 * n]});
    end
    // Ratios formed by software in both formats, ratio 0 selected by hand
    avld = 1'b0;
    for (int f = 0; f < 2; f++) begin
      r = f ? (64'd12288000 << 20) / 64'd10000000 : (64'd12288000 << 12) / 64'd60;
      for (int b = 0; b < 4; b++) wrt(8'h06 + b[7:0], r[31 - 8 * b -: 8]);
      wrt(`PFCR_ADDR_FUNC_CFG_TWO, {4'h0, f[0], 3'h0});
      wrt(`PFCR_ADDR_DEV_CFG_TWO, {7'h00, ~f[0]});
      wt(4);
      check(o_ratio_ff, r[31:0]);
      check(o_ratio_12_20_ff, f[0]);
    end
    for (int c = 0; c < 8; c++) begin
      wrt(`PFCR_ADDR_FUNC_CFG_THREE, {1'b0, c[2:0], 4'h0});
      wt(2);
      check(o_min_bw_hz_ff, 8'h01 << c);
      check(o_min_bw_applied_ff, c[2:0]);
    end
    lock = 1'b1;
    wt(4);
    wrt(`PFCR_ADDR_FUNC_CFG_THREE, 8'h30);
    wt(2);
    check({o_min_bw_hz_ff, o_min_bw_applied_ff}, {8'h08, 3'h7});
    lock = 1'b0;
    wt(4);
    check(o_min_bw_applied_ff, 3'h3);
    for (int u = 0; u < 2; u++) begin
      wrt(`PFCR_ADDR_FUNC_CFG_TWO, {3'h0, u[0], 4'h0});
      wt(4);
      count(1'b1, 8);
      check(k, u ? 4 : 0);
      lock = 1'b1;
      wt(4);
      count(1'b1, 8);
      check(k, 4);
      lock = 1'b0;
    end
    for (int c = 0; c < 4; c++) begin
      wrt(`PFCR_ADDR_FUNC_CFG_ONE, {3'h0, c[1:0], 3'h0});
      wt(4);
      count(1'b0, 16);
      check(k, c == 3 ? 0 : 4 << c);
    end
    summarize();
  end
endmodule
`default_nettype wire
